// File: src/rcp_pkg.sv
/*
 Package for the reset-cause and protect-mode register group: register
 offsets, field positions, reset and cause values, bus encodings.
 Assumes a 32-bit AHB-Lite register bus and one clock domain.
*/
package rcp_pkg;

  localparam logic [7:0]  OFF_CHIP_ID_EXT  = 8'h04;
  localparam logic [7:0]  OFF_RESET_CAUSE  = 8'h08;
  localparam logic [7:0]  OFF_PROTECT_CTRL = 8'h18;
  localparam int          ADDR_W           = 8;

  localparam logic [7:0]  CAUSE_EXT_PIN    = 8'h6c;
  localparam logic [7:0]  CAUSE_WATCHDOG   = 8'h53;
  localparam logic [7:0]  CAUSE_RESET      = 8'h6c;

  localparam logic [15:0] PROTECT_KEY      = 16'h27a8;
  localparam int          KEY_LSB          = 16;
  localparam int          PROT_EN_BIT      = 5;
  localparam logic        PROT_EN_RESET    = 1'b0;

  // Reserved extension register reads as zero
  localparam logic [31:0] CHIP_ID_EXT_VAL  = 32'h0000_0000;

  localparam logic [1:0]  HTRANS_NONSEQ    = 2'h2;
  localparam logic [2:0]  HSIZE_WORD       = 3'h2;

  typedef struct packed {
    logic              wr;
    logic [ADDR_W-1:0] addr;
  } rcp_req_t;

endpackage : rcp_pkg

// File: src/rcp_cause_latch.sv
/*
 Reset-cause latch: remembers which source caused the last reset.
 Assumes both cause inputs are already synchronised to mclk and held
 at least one cycle while rst is high.
*/
module rcp_cause_latch (
  input  wire logic       mclk,
  input  wire logic       rst,
  input  wire logic       pin_cause,
  input  wire logic       wdog_cause,
  output logic [7:0]      cause_ff
);

  logic       seen_wd_ff;
  logic [7:0] nxt_cause;

  // Watchdog wins unless the pin was seen alone after it, during or after the reset
  assign nxt_cause = seen_wd_ff ? rcp_pkg::CAUSE_WATCHDOG
                                : rcp_pkg::CAUSE_EXT_PIN;

  always_ff @(posedge mclk) begin
    if (rst) begin
      // Pin clears an old watchdog mark; watchdog still wins if both
      seen_wd_ff <= wdog_cause | (seen_wd_ff & ~pin_cause);
      cause_ff   <= rcp_pkg::CAUSE_RESET;
    end else begin
      cause_ff   <= nxt_cause;
      seen_wd_ff <= seen_wd_ff & ~pin_cause;
    end
  end

endmodule : rcp_cause_latch

// File: src/rcp_regs.sv
/*
 Reset-cause and protect-mode register group, AHB-Lite slave.
 Assumes one AHB-Lite master, single word transfers, hsel decoded
 outside; cause inputs are pins and get synchronised here.
*/
// The implementer's own choices: the placing of the registers and the AHB-Lite register port.
module rcp_regs (
  input  wire logic        mclk,
  input  wire logic        rst,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        external_reset_pin,
  input  wire logic        wdog_reset_req,
  output logic             irq_ctrl_protect_enable
);

  logic               pin_s1_ff;
  logic               pin_s2_ff;
  logic               wd_s1_ff;
  logic               wd_s2_ff;
  logic [7:0]         cause_ff;
  rcp_pkg::rcp_req_t  req_ff;
  logic               req_vld_ff;
  logic               prot_en_ff;
  logic [31:0]        rdata_ff;

  // Two-stage synchronisers for the reset source pins
  always_ff @(posedge mclk) begin
    pin_s1_ff <= external_reset_pin;
    pin_s2_ff <= pin_s1_ff;
    wd_s1_ff  <= wdog_reset_req;
    wd_s2_ff  <= wd_s1_ff;
  end

  rcp_cause_latch u_cause (
    .mclk       (mclk),
    .rst        (rst),
    .pin_cause  (pin_s2_ff),
    .wdog_cause (wd_s2_ff),
    .cause_ff   (cause_ff)
  );

  wire addr_take = hsel & hready & (htrans == rcp_pkg::HTRANS_NONSEQ);
  wire wr_data   = req_vld_ff & req_ff.wr;
  wire hit_prot  = req_ff.addr == rcp_pkg::OFF_PROTECT_CTRL;
  wire key_ok    = hwdata[31:rcp_pkg::KEY_LSB] == rcp_pkg::PROTECT_KEY;
  wire prot_we   = wr_data & hit_prot & key_ok;
  wire nxt_prot_en = prot_we ? hwdata[rcp_pkg::PROT_EN_BIT] : prot_en_ff;

  wire [rcp_pkg::ADDR_W-1:0] rd_addr = haddr[rcp_pkg::ADDR_W-1:0];
  wire hi_zero = haddr[31:rcp_pkg::ADDR_W] == '0;
  wire [31:0] prot_rd = {16'h0000, 10'h000, prot_en_ff, 5'h00};
  wire [31:0] nxt_rdata =
      !hi_zero ? 32'h0000_0000 :
      (rd_addr == rcp_pkg::OFF_CHIP_ID_EXT)  ? rcp_pkg::CHIP_ID_EXT_VAL :
      (rd_addr == rcp_pkg::OFF_RESET_CAUSE)  ? {24'h000000, cause_ff} :
      (rd_addr == rcp_pkg::OFF_PROTECT_CTRL) ? prot_rd :
      32'h0000_0000;

  always_ff @(posedge mclk) begin
    if (rst) begin
      req_vld_ff <= 1'b0;
      req_ff     <= '0;
      rdata_ff   <= 32'h0000_0000;
    end else begin
      req_vld_ff <= addr_take;
      if (addr_take) begin
        req_ff.wr   <= hwrite;
        req_ff.addr <= hi_zero ? rd_addr : '1;
        rdata_ff    <= hwrite ? 32'h0000_0000 : nxt_rdata;
      end
    end
  end

  // Only the protect register is writable; other writes drop
  always_ff @(posedge mclk) begin
    if (rst) begin
      prot_en_ff <= rcp_pkg::PROT_EN_RESET;
    end else begin
      prot_en_ff <= nxt_prot_en;
    end
  end

  assign hrdata                  = rdata_ff;
  assign hreadyout               = 1'b1;
  assign hresp                   = 1'b0;
  assign irq_ctrl_protect_enable = prot_en_ff;

  property p_key_write;
    @(posedge mclk) disable iff (rst)
      prot_we |=> irq_ctrl_protect_enable == $past(hwdata[5]);
  endproperty
  a_key_write: assert property (p_key_write)
    else $error("protect bit not loaded by keyed write");

  property p_bad_key;
    @(posedge mclk) disable iff (rst)
      (wr_data && hit_prot && !key_ok) |=> $stable(prot_en_ff);
  endproperty
  a_bad_key: assert property (p_bad_key)
    else $error("protect bit changed without key");

  property p_ro_write;
    @(posedge mclk) disable iff (rst)
      (wr_data && !hit_prot) |=> $stable(prot_en_ff);
  endproperty
  a_ro_write: assert property (p_ro_write)
    else $error("read-only write changed state");

  property p_key_reads_zero;
    @(posedge mclk) disable iff (rst)
      (addr_take && !hwrite && haddr == 32'h18) |=> hrdata[31:16] == 0;
  endproperty
  a_key_reads_zero: assert property (p_key_reads_zero)
    else $error("key field read nonzero");

  property p_prot_read;
    @(posedge mclk) disable iff (rst)
      (addr_take && !hwrite && haddr == 32'h18 && !prot_we)
        |=> hrdata[5] == irq_ctrl_protect_enable;
  endproperty
  a_prot_read: assert property (p_prot_read)
    else $error("protect bit readback mismatch");

  property p_cause_val;
    @(posedge mclk) disable iff (rst)
      (addr_take && !hwrite && haddr == 32'h08)
        |=> hrdata == 32'h6c || hrdata == 32'h53;
  endproperty
  a_cause_val: assert property (p_cause_val)
    else $error("reset cause value illegal");

  property p_ext_zero;
    @(posedge mclk) disable iff (rst)
      (addr_take && !hwrite && haddr == 32'h04) |=> hrdata == 0;
  endproperty
  a_ext_zero: assert property (p_ext_zero)
    else $error("extension register not zero");

  property p_reset_normal;
    @(posedge mclk) $fell(rst) |-> !irq_ctrl_protect_enable;
  endproperty
  a_reset_normal: assert property (p_reset_normal)
    else $error("protect mode set after reset");

  property p_okay;
    @(posedge mclk) disable iff (rst) hreadyout && !hresp;
  endproperty
  a_okay: assert property (p_okay)
    else $error("slave not ready or error");

  c_key_write: cover property (@(posedge mclk) disable iff (rst) prot_we);
  c_bad_key: cover property (@(posedge mclk) disable iff (rst)
    wr_data && hit_prot && !key_ok);
  c_prot_on: cover property (@(posedge mclk) disable iff (rst)
    $rose(irq_ctrl_protect_enable));
  c_wd_cause: cover property (@(posedge mclk) disable iff (rst)
    cause_ff == rcp_pkg::CAUSE_WATCHDOG);

endmodule : rcp_regs

// File: verification/tb_reset_cause_and_protect_regs.sv
/*
 Testbench for the reset-cause and protect-mode register group.
 Assumes zero-wait AHB-Lite slave, hready fed back from hreadyout.
*/
module tb_reset_cause_and_protect_regs;
  timeunit 1ns;
  timeprecision 1ps;
  logic        mclk = 1'b0;
  logic        rst = 1'b1;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        pin = 1'b1;
  logic        wdog = 1'b0;
  logic        prot;
  int          errors = 0;
  int          n_compared = 0;
  always #4 mclk = ~mclk;
  rcp_regs rcp_regs_i (.mclk(mclk), .rst(rst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(rcp_pkg::HSIZE_WORD),
    .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(), .external_reset_pin(pin),
    .wdog_reset_req(wdog), .irq_ctrl_protect_enable(prot));
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
            output logic [31:0] r);
    @(posedge mclk);
    hsel <= 1'b1; haddr <= {24'h0, a};
    htrans <= rcp_pkg::HTRANS_NONSEQ; hwrite <= w;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0; htrans <= 2'h0; hwdata <= d;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    r = hrdata;
    #1;
  endtask : xfer
  task rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] r;
    xfer(1'b0, a, 32'h0, r);
    chk(r, e);
  endtask : rd
  task wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    xfer(1'b1, a, d, r);
  endtask : wr
  // Held five edges: cause synchronisers need three inside reset
  task do_reset(input logic p, input logic w);
    @(posedge mclk);
    rst <= 1'b1; pin <= p; wdog <= w;
    repeat (5) @(posedge mclk);
    rst <= 1'b0; pin <= 1'b0; wdog <= 1'b0;
  endtask : do_reset
  task t_key;
    wr(8'h18, 32'h27a9_0020);
    chk(prot, 1'b0);
    rd(8'h18, 32'h0);
    wr(8'h18, {rcp_pkg::PROTECT_KEY, 16'h0020});
    chk(prot, 1'b1);
    rd(8'h18, 32'h0000_0020);
    wr(8'h18, 32'h0000_0000);
    chk(prot, 1'b1);
    wr(8'h18, {rcp_pkg::PROTECT_KEY, 16'h0000});
    chk(prot, 1'b0);
  endtask : t_key
  task t_readonly;
    wr(8'h18, {rcp_pkg::PROTECT_KEY, 16'h0020});
    wr(8'h04, 32'hffff_ffff);
    wr(8'h08, 32'hffff_ffff);
    wr(8'h0c, 32'hffff_ffff);
    chk(prot, 1'b1);
    rd(8'h04, rcp_pkg::CHIP_ID_EXT_VAL);
    rd(8'h08, 32'h0000_006c);
    rd(8'h0c, 32'h0);
    rd(8'h18, 32'h0000_0020);
  endtask : t_readonly
  task t_causes;
    do_reset(1'b0, 1'b1);
    rd(8'h08, 32'h0000_0053);
    chk(prot, 1'b0);
    do_reset(1'b1, 1'b0);
    rd(8'h08, 32'h0000_006c);
  endtask : t_causes
  task report_and_stop;
    $display("errors=%0d compared=%0d", errors, n_compared);
    if (errors == 0 && n_compared > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : report_and_stop
  initial begin
    repeat (5) @(posedge mclk);
    rst <= 1'b0;
    pin <= 1'b0;
    rd(8'h08, 32'h0000_006c);
    rd(8'h18, 32'h0);
    chk(prot, 1'b0);
    t_key();
    t_readonly();
    t_causes();
    report_and_stop();
  end
  initial begin
    #20000;
    errors++;
    report_and_stop();
  end
endmodule : tb_reset_cause_and_protect_regs
